/* File: hdl/sgs_gate_top.sv */
// signature analyser gate, stop counter, signature and event counter
// Summary of operation
// - clock edge mode selects rising, falling or both edges
// - clock source is the pod access strobe or the clock clip lead
// - enable level qualifies clocking; invalid enable inhibits pulses
// - start edges are ignored unless the gate is armed
// - armed gate goes started on the first selected start edge
// - started gate goes stopped on first stop edge; later ones ignored
// - start and stop detection does not depend on enable
// - gate open only when started, not stopped, and enable asserted
// - only gated pulses move signature and event counter
// - start then stop with no clock between gives no gated pulse
// - a pulse already passing at stop completes at full width
// - enable can be forced permanently asserted
// - start, stop, clock edge detected, enable level; polarity chosen
// - both-edge mode makes one narrow pulse per clock edge
// - signature is read out as a 16-bit value
// - event counter counts data transitions unless free-run is chosen
// - stop counter decrements once per gated pulse only
// - stop counter at zero stops the gate like a stop edge
// - counter stop and external stop: whichever comes first wins
// - probe data delay selectable in one-clock (4 ns) steps, 3 ns rounded up, up to 12 steps
// - after start the next valid clock edge begins clocking
// - first valid clock edge after stop clocks nothing in
// - forced read ends a measurement with or without a stop
// - waveform holds probe samples before stop, one per 20 ns
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
module sgs_gate_top
  import sgs_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int EVT_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [sgs_pkg::SGS_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // pins from the circuit under test and the interface pod
  input wire logic probe_pin,
  input wire logic enable_pin,
  input wire logic clk_clip_pin,
  input wire logic start_clip_pin,
  input wire logic stop_clip_pin,
  input wire logic pod_strobe_pin,
  // status
  output logic gate_open,
  output logic meas_done
);
  import sgs_pkg::*;

  localparam int DLY_LEN = SGS_DELAY_STEPS * SGS_DELAY_STEP_CYC;
  localparam int WAW = $clog2(SGS_WAVE_DEPTH);

  typedef struct packed {
    sgs_gate_t gate;
    logic [SGS_CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0] preset;
    logic [CNT_W-1:0] stop_cnt;
    logic [15:0] sig;
    logic [EVT_W-1:0] events;
    logic prev_bit;
    logic forced;
    logic [WAW-1:0] widx;
    logic [WAW-1:0] wptr;
    logic [2:0] div;
    logic [DLY_LEN-1:0] dly;
    logic clk_d;
    logic start_d;
    logic stop_d;
    logic [31:0] rdata;
    logic rd_wave;
  } sgs_state_t;

  sgs_state_t s_ff;
  sgs_state_t nxt_s;

  logic [5:0] pins_s;
  logic probe_s, en_s, clkc_s, startc_s, stopc_s, pod_s;
  logic wave_q;
  logic wave_we;
  logic data_bit;
  logic clk_pulse, start_edge, stop_edge, en_ok, gated, cnt_stop;
  logic arm_cmd, force_cmd;

  // selected edge of a synchronised input
  function automatic logic sel_edge(logic cur, logic prev, logic pol);
    sel_edge = (cur != prev) && (cur == pol);
  endfunction

  // one shift of the signature register
  function automatic logic [15:0] lfsr_step(logic [15:0] r, logic d);
    lfsr_step = {r[14:0], d ^ r[6] ^ r[8] ^ r[11] ^ r[15]};
  endfunction

  sgs_sync #(
    .W(6)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in({probe_pin, enable_pin, clk_clip_pin, start_clip_pin,
             stop_clip_pin, pod_strobe_pin}),
    .sync_out(pins_s)
  );

  assign {probe_s, en_s, clkc_s, startc_s, stopc_s, pod_s} = pins_s;

  sgs_wave_mem #(
    .W(1),
    .DEPTH(SGS_WAVE_DEPTH),
    .AW(WAW)
  ) u_wave (
    .clk(clk),
    .rst_n(rst_n),
    .we(wave_we),
    .waddr(s_ff.wptr),
    .wdata(data_bit),
    .raddr(WAW'(s_ff.wptr + s_ff.widx)),
    .rdata(wave_q)
  );

  always_comb
  begin
    logic clk_raw;
    logic start_raw;
    logic stop_raw;
    logic [3:0] dsel;
    clk_raw = 1'b0;
    start_raw = 1'b0;
    stop_raw = 1'b0;
    dsel = 4'h0;
    nxt_s = s_ff;
    // source selection per control signal
    clk_raw = s_ff.ctrl[SGS_CLK_SRC_BIT] ? pod_s : clkc_s;
    start_raw = s_ff.ctrl[SGS_START_SRC_BIT] ? pod_s : startc_s;
    stop_raw = s_ff.ctrl[SGS_STOP_SRC_BIT] ? pod_s : stopc_s;
    nxt_s.clk_d = clk_raw;
    nxt_s.start_d = start_raw;
    nxt_s.stop_d = stop_raw;
    // each selected edge yields a one-cycle pulse, narrow by construction
    unique case (s_ff.ctrl[SGS_CLK_MODE_LSB +: 2])
      SGS_MODE_RISE: clk_pulse = clk_raw & ~s_ff.clk_d;
      SGS_MODE_FALL: clk_pulse = ~clk_raw & s_ff.clk_d;
      default: clk_pulse = clk_raw ^ s_ff.clk_d;
    endcase
    start_edge = sel_edge(start_raw, s_ff.start_d,
                          s_ff.ctrl[SGS_START_POL_BIT]);
    stop_edge = sel_edge(stop_raw, s_ff.stop_d,
                         s_ff.ctrl[SGS_STOP_POL_BIT]);
    en_ok = s_ff.ctrl[SGS_EN_FORCE_BIT]
            | (en_s == s_ff.ctrl[SGS_EN_POL_BIT]);
    // delay line; one step is the step time rounded up to whole clock periods
    nxt_s.dly = {s_ff.dly[DLY_LEN-2:0], probe_s};
    dsel = s_ff.ctrl[SGS_DELAY_LSB +: 4];
    if (dsel > 4'(SGS_DELAY_STEPS))
    begin
      dsel = 4'(SGS_DELAY_STEPS);
    end
    data_bit = (dsel == 4'h0) ? probe_s
      : s_ff.dly[int'(dsel) * SGS_DELAY_STEP_CYC - 1];
    // start takes effect next cycle, so a clock in the start cycle
    // and any clock after stop are never passed; a clock in the stop
    // cycle still sees the started gate and goes through whole
    gated = clk_pulse && (s_ff.gate == SGS_STARTED)
            && en_ok;
    cnt_stop = s_ff.ctrl[SGS_STOPCNT_EN_BIT] && gated
               && (s_ff.stop_cnt == CNT_W'(1));
    if (gated)
    begin
      nxt_s.sig = lfsr_step(s_ff.sig, data_bit);
      nxt_s.prev_bit = data_bit;
      if (s_ff.ctrl[SGS_FREERUN_BIT] || (data_bit != s_ff.prev_bit))
      begin
        nxt_s.events = s_ff.events + EVT_W'(1);
      end
      if (s_ff.ctrl[SGS_STOPCNT_EN_BIT] && (s_ff.stop_cnt != '0))
      begin
        nxt_s.stop_cnt = s_ff.stop_cnt - CNT_W'(1);
      end
    end
    // gate sequence; enable is not consulted here
    unique case (s_ff.gate)
      SGS_ARMED:
      begin
        if (start_edge)
        begin
          nxt_s.gate = SGS_STARTED;
        end
      end
      SGS_STARTED:
      begin
        if (stop_edge || cnt_stop)
        begin
          nxt_s.gate = SGS_STOPPED;
        end
      end
      SGS_IDLE, SGS_STOPPED:
      begin
        nxt_s.gate = s_ff.gate;
      end
    endcase
    // waveform: one sample per 20 ns until the gate stops
    wave_we = 1'b0;
    if ((s_ff.gate == SGS_ARMED) || (s_ff.gate == SGS_STARTED))
    begin
      if (s_ff.div == 3'(SGS_SAMPLE_CYC - 1))
      begin
        nxt_s.div = 3'h0;
        wave_we = 1'b1;
        nxt_s.wptr = s_ff.wptr + WAW'(1);
      end
      else
      begin
        nxt_s.div = s_ff.div + 3'h1;
      end
    end
    // register writes
    arm_cmd = wr && (addr == SGS_REG_CMD) && wdata[SGS_CMD_ARM_BIT];
    force_cmd = wr && (addr == SGS_REG_CMD) && wdata[SGS_CMD_FORCE_BIT];
    if (wr && (addr == SGS_REG_CTRL))
    begin
      nxt_s.ctrl = wdata[SGS_CTRL_W-1:0];
    end
    if (wr && (addr == SGS_REG_PRESET))
    begin
      nxt_s.preset = wdata[CNT_W-1:0];
    end
    if (wr && (addr == SGS_REG_WIDX))
    begin
      nxt_s.widx = wdata[WAW-1:0];
    end
    // arm outranks a forced stop written in the same cycle
    if (arm_cmd)
    begin
      nxt_s.gate = SGS_ARMED;
      nxt_s.sig = SGS_SIG_RESET;
      nxt_s.events = '0;
      nxt_s.prev_bit = 1'b0;
      nxt_s.forced = 1'b0;
      nxt_s.stop_cnt = s_ff.preset;
      nxt_s.div = 3'h0;
    end
    else if (force_cmd && (s_ff.gate != SGS_IDLE))
    begin
      nxt_s.gate = SGS_STOPPED;
      nxt_s.forced = (s_ff.gate != SGS_STOPPED) || s_ff.forced;
    end
    // register reads, answered in the next cycle
    nxt_s.rd_wave = rd && (addr == SGS_REG_WDATA);
    nxt_s.rdata = 32'h0000_0000;
    if (rd)
    begin
      unique case (addr)
        SGS_REG_CTRL: nxt_s.rdata = 32'(s_ff.ctrl);
        SGS_REG_PRESET: nxt_s.rdata = 32'(s_ff.preset);
        SGS_REG_STATUS:
          nxt_s.rdata = 32'({s_ff.stop_cnt, 13'h0000, s_ff.forced,
                             s_ff.gate});
        SGS_REG_SIG: nxt_s.rdata = 32'(s_ff.sig);
        SGS_REG_EVENTS: nxt_s.rdata = 32'(s_ff.events);
        SGS_REG_WIDX: nxt_s.rdata = 32'(s_ff.widx);
        default: nxt_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_ff <= '0;
      s_ff.gate <= SGS_IDLE;
      s_ff.ctrl <= SGS_CTRL_RESET;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign rdata = s_ff.rd_wave ? {31'h0000_0000, wave_q} : s_ff.rdata;
  assign gate_open = (s_ff.gate == SGS_STARTED) && en_ok;
  assign meas_done = (s_ff.gate == SGS_STOPPED);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_started;
    s_ff.gate == SGS_STARTED;
  endsequence
  sequence seq_stop_seen;
    seq_started ##0 (stop_edge || cnt_stop) && !arm_cmd && !force_cmd;
  endsequence

  a_start_ignored: assert property (
    ((s_ff.gate == SGS_IDLE) || (s_ff.gate == SGS_STOPPED)) && !arm_cmd
    && start_edge |=> s_ff.gate != SGS_STARTED)
    else $error("start edge moved an unarmed gate");
  a_start_taken: assert property (
    (s_ff.gate == SGS_ARMED) && start_edge && !arm_cmd && !force_cmd
    |=> seq_started)
    else $error("armed gate missed start edge");
  a_stop_taken: assert property (
    seq_stop_seen |=> (s_ff.gate == SGS_STOPPED) [*2])
    else $error("started gate missed stop");
  a_gate_only: assert property (
    !gated && !arm_cmd |=> $stable(s_ff.sig) && $stable(s_ff.events))
    else $error("signature moved without gated pulse");
  a_enable_blocks: assert property (
    clk_pulse && !en_ok && !arm_cmd
    |=> $stable(s_ff.sig) && $stable(s_ff.stop_cnt))
    else $error("pulse passed with enable invalid");
  a_no_after_stop: assert property (
    (s_ff.gate == SGS_STOPPED) && clk_pulse && en_ok && !arm_cmd
    |=> $stable(s_ff.sig) && $stable(s_ff.events))
    else $error("clock passed after stop");
  a_stop_full_pulse: assert property (
    seq_stop_seen ##0 (clk_pulse && en_ok)
    |=> s_ff.sig == lfsr_step($past(s_ff.sig), $past(data_bit)))
    else $error("pulse in the stop cycle was cut");
  a_stopcnt_dec: assert property (
    gated && s_ff.ctrl[SGS_STOPCNT_EN_BIT] && (s_ff.stop_cnt != '0)
    && !arm_cmd |=> s_ff.stop_cnt == $past(s_ff.stop_cnt) - CNT_W'(1))
    else $error("stop counter did not step");
  a_cnt_stop: assert property (
    cnt_stop && !arm_cmd |=> s_ff.gate == SGS_STOPPED)
    else $error("stop counter zero did not stop gate");
  a_arm_clears: assert property (
    arm_cmd |=> (s_ff.gate == SGS_ARMED) && (s_ff.sig == SGS_SIG_RESET)
    && (s_ff.events == '0) && (s_ff.stop_cnt == $past(s_ff.preset)))
    else $error("arm did not clear results");
  a_force_stop: assert property (
    force_cmd && !arm_cmd && (s_ff.gate == SGS_STARTED)
    |=> meas_done && s_ff.forced)
    else $error("forced read did not end measurement");
endmodule

/* File: hdl/sgs_pkg.sv */
// constants and types shared by the signature gate block
package sgs_pkg;
  // register byte offsets
  localparam logic [4:0] SGS_REG_CTRL = 5'h00;
  localparam logic [4:0] SGS_REG_CMD = 5'h04;
  localparam logic [4:0] SGS_REG_PRESET = 5'h08;
  localparam logic [4:0] SGS_REG_STATUS = 5'h0C;
  localparam logic [4:0] SGS_REG_SIG = 5'h10;
  localparam logic [4:0] SGS_REG_EVENTS = 5'h14;
  localparam logic [4:0] SGS_REG_WIDX = 5'h18;
  localparam logic [4:0] SGS_REG_WDATA = 5'h1C;
  localparam int SGS_ADDR_W = 5;
  // control register fields
  localparam int SGS_CTRL_W = 16;
  localparam int SGS_CLK_MODE_LSB = 0;
  localparam int SGS_CLK_SRC_BIT = 2;
  localparam int SGS_START_SRC_BIT = 3;
  localparam int SGS_STOP_SRC_BIT = 4;
  localparam int SGS_START_POL_BIT = 5;
  localparam int SGS_STOP_POL_BIT = 6;
  localparam int SGS_EN_POL_BIT = 7;
  localparam int SGS_EN_FORCE_BIT = 8;
  localparam int SGS_STOPCNT_EN_BIT = 9;
  localparam int SGS_FREERUN_BIT = 10;
  localparam int SGS_DELAY_LSB = 12;
  localparam logic [15:0] SGS_CTRL_RESET = 16'h40E0;
  // command register bits
  localparam int SGS_CMD_ARM_BIT = 0;
  localparam int SGS_CMD_FORCE_BIT = 1;
  // clock edge modes
  localparam logic [1:0] SGS_MODE_RISE = 2'h0;
  localparam logic [1:0] SGS_MODE_FALL = 2'h1;
  localparam logic [1:0] SGS_MODE_BOTH = 2'h2;
  // timing
  localparam int SGS_CLK_NS = 4;
  localparam int SGS_SAMPLE_NS = 20;
  localparam int SGS_SAMPLE_CYC = SGS_SAMPLE_NS / SGS_CLK_NS;
  localparam int SGS_DELAY_STEP_NS = 3;
  localparam int SGS_DELAY_STEP_CYC =
    (SGS_DELAY_STEP_NS + SGS_CLK_NS - 1) / SGS_CLK_NS;
  localparam int SGS_DELAY_STEPS = 12;
  localparam logic [3:0] SGS_DELAY_DEFAULT = 4'h4;
  localparam int SGS_WAVE_DEPTH = 32;
  localparam logic [15:0] SGS_SIG_RESET = 16'h0000;
  // gate states
  typedef enum logic [1:0] {
    SGS_IDLE,
    SGS_ARMED,
    SGS_STARTED,
    SGS_STOPPED
  } sgs_gate_t;
endpackage

/* File: hdl/sgs_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sgs_sync #(
  parameter int W = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in, synchronised levels out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } sgs_sync_t;

  sgs_sync_t s_ff;
  sgs_sync_t nxt_s;

  always_comb
  begin
    nxt_s.meta = pin_in;
    nxt_s.safe = s_ff.meta;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign sync_out = s_ff.safe;
endmodule

/* File: hdl/sgs_wave_mem.sv */
// small sample memory for the waveform capture, registered read
`timescale 1ns/1ps
module sgs_wave_mem #(
  parameter int W = 1,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] q;
  } sgs_mem_t;

  sgs_mem_t m_ff;
  sgs_mem_t nxt_m;

  always_comb
  begin
    nxt_m = m_ff;
    nxt_m.q = m_ff.mem[raddr];
    if (we)
    begin
      nxt_m.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      m_ff <= '0;
    end
    else
    begin
      m_ff <= nxt_m;
    end
  end

  assign rdata = m_ff.q;
endmodule

/* File: tb/sgs_uut_model.sv */
// behavioural circuit under test driving the probe and control leads
`timescale 1ns/1ps
module sgs_uut_model (
  // system clock, only used to pace the leads
  input wire logic clk,
  // leads toward the analyser
  output logic probe_pin,
  output logic enable_pin,
  output logic clk_clip_pin,
  output logic start_clip_pin,
  output logic stop_clip_pin,
  output logic pod_strobe_pin
);
  logic use_pod = 1'b0;
  initial
  begin
    probe_pin = 1'b0;
    enable_pin = 1'b1;
    clk_clip_pin = 1'b0;
    start_clip_pin = 1'b0;
    stop_clip_pin = 1'b0;
    pod_strobe_pin = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic setup(input logic e, input logic p);
    enable_pin <= e;
    use_pod = p;
  endtask
  // each level stays 10 cycles, far above the two sync flops
  task automatic edge_pulse(input logic stop);
    @(posedge clk);
    if (stop)
      stop_clip_pin <= 1'b1;
    else
      start_clip_pin <= 1'b1;
    hold(10);
    stop_clip_pin <= 1'b0;
    start_clip_pin <= 1'b0;
    hold(10);
  endtask
  // 160 ns link period; data settles 10 cycles (40 ns) before each edge
  task automatic clocks(input int n, input logic [15:0] d);
    @(posedge clk);
    for (int i = 0; i < 2 * n; i++)
    begin
      probe_pin <= d[i % 16];
      hold(10);
      if (use_pod)
        pod_strobe_pin <= ~pod_strobe_pin;
      else
        clk_clip_pin <= ~clk_clip_pin;
      hold(10);
    end
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the signature gate block
`timescale 1ns/1ps
module testbench;
  import sgs_pkg::*;
  typedef struct {
    logic [15:0] ctrl;
    logic en;
    int n;
    logic [15:0] d;
  } sgs_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [SGS_ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic probe_pin, enable_pin, clk_clip_pin;
  logic start_clip_pin, stop_clip_pin, pod_strobe_pin;
  logic gate_open;
  logic meas_done;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [15:0] es;
  logic [31:0] ee;
  logic pl;
  sgs_row_t rows [10] = '{
    '{16'h40E0, 1'b1, 4, 16'hA5C3},
    '{16'h40E1, 1'b1, 4, 16'hA5C3},
    '{16'h40E2, 1'b1, 3, 16'h3C96},
    '{16'h40E3, 1'b1, 3, 16'h0F1E},
    '{16'h40E4, 1'b1, 5, 16'h5A33},
    '{16'h44E0, 1'b1, 5, 16'h5A33},
    '{16'h4060, 1'b0, 4, 16'h9C3A},
    '{16'h41E0, 1'b0, 4, 16'h9C3A},
    '{16'h00E0, 1'b1, 6, 16'h7B2D},
    '{16'hC2E0, 1'b1, 6, 16'h7B2D}
  };

  always #2 clk = ~clk;

  sgs_gate_top u_dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .probe_pin(probe_pin),
    .enable_pin(enable_pin), .clk_clip_pin(clk_clip_pin),
    .start_clip_pin(start_clip_pin), .stop_clip_pin(stop_clip_pin),
    .pod_strobe_pin(pod_strobe_pin), .gate_open(gate_open),
    .meas_done(meas_done)
  );
  sgs_uut_model u_uut (
    .clk(clk), .probe_pin(probe_pin), .enable_pin(enable_pin),
    .clk_clip_pin(clk_clip_pin), .start_clip_pin(start_clip_pin),
    .stop_clip_pin(stop_clip_pin), .pod_strobe_pin(pod_strobe_pin)
  );

  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [SGS_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [SGS_ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [15:0] step(logic [15:0] r, logic b);
    return {r[14:0], b ^ r[6] ^ r[8] ^ r[11] ^ r[15]};
  endfunction
  // golden model: which half periods give a gated sample, and what it adds;
  // data moves 10 cycles before each clock edge, so a longer delay line
  // hands over the previous bit (pl is the probe level before the row)
  task automatic expect_row(input sgs_row_t w, input logic pl,
                            output logic [15:0] s, output logic [31:0] e);
    logic p;
    logic b;
    logic late;
    s = SGS_SIG_RESET;
    e = '0;
    p = 1'b0;
    late = int'(w.ctrl[SGS_DELAY_LSB +: 4]) * SGS_DELAY_STEP_CYC
           > 10;
    for (int i = 0; i < 2 * w.n; i++)
    begin
      b = !late ? w.d[i % 16] : (i == 0) ? pl : w.d[(i - 1) % 16];
      if (w.ctrl[1] || (w.ctrl[0] == i[0]))
      begin
        s = step(s, b);
        e += (w.ctrl[SGS_FREERUN_BIT] || b != p) ? 1 : 0;
        p = b;
      end
    end
  endtask
  task automatic arm_start(input sgs_row_t w, input logic [15:0] pre);
    wr_reg(SGS_REG_CTRL, {16'h0, w.ctrl});
    wr_reg(SGS_REG_PRESET, {16'h0, pre});
    u_uut.setup(w.en, w.ctrl[SGS_CLK_SRC_BIT]);
    wr_reg(SGS_REG_CMD, 32'h1);
    u_uut.edge_pulse(1'b0);
  endtask
  task automatic results(input logic [15:0] s, input logic [31:0] e,
                         input logic [1:0] g);
    rd_reg(SGS_REG_STATUS, v);
    chk("gate state", {30'h0, v[1:0]}, {30'h0, g});
    chk("done", {31'h0, meas_done}, {31'h0, g == 2'h3});
    rd_reg(SGS_REG_SIG, v);
    chk("signature", v, {16'h0, s});
    rd_reg(SGS_REG_EVENTS, v);
    chk("events", v, e);
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hang is cut off well past the few thousand cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  initial
  begin
    do_reset();
    foreach (rows[k])
    begin
      arm_start(rows[k], 16'd50);
      chk("gate_open", {31'h0, gate_open}, 32'h1);
      pl = probe_pin;
      u_uut.clocks(rows[k].n, rows[k].d);
      u_uut.edge_pulse(1'b1);
      expect_row(rows[k], pl, es, ee);
      results(es, ee, 2'h3);
      wr_reg(SGS_REG_WIDX, 32'd31);
      rd_reg(SGS_REG_WDATA, v);
      chk("wave", {31'h0, v[0]},
          {31'h0, rows[k].d[2 * rows[k].n - 1]});
      $display("row %0d done", k);
    end
    // second reset in mid-run, then a start while idle
    do_reset();
    rd_reg(SGS_REG_CTRL, v);
    chk("ctrl reset", v, {16'h0, SGS_CTRL_RESET});
    rd_reg(5'h03, v);
    chk("unmapped", v, 32'h0);
    u_uut.edge_pulse(1'b0);
    u_uut.clocks(2, 16'hFFFF);
    results(SGS_SIG_RESET, 0, 2'h0);
    $display("reset test done");
    // start and stop with no clock between, then edges after stop
    arm_start(rows[0], 16'd0);
    u_uut.edge_pulse(1'b1);
    u_uut.edge_pulse(1'b0);
    u_uut.clocks(3, 16'hFFFF);
    results(SGS_SIG_RESET, 0, 2'h3);
    $display("empty window test done");
    // start while enable invalid; two pulses masked; count of 3 stops it
    arm_start('{16'h42E0, 1'b0, 0, 16'h0}, 16'd3);
    chk("gate_open", {31'h0, gate_open}, 32'h0);
    u_uut.setup(1'b1, 1'b0);
    u_uut.clocks(1, 16'h0005);
    u_uut.setup(1'b0, 1'b0);
    u_uut.clocks(2, 16'h0005);
    u_uut.setup(1'b1, 1'b0);
    u_uut.clocks(4, 16'h0005);
    results(16'h0007, 1, 2'h3);
    $display("stop count test done");
    // forced read mid-window, then a fresh arm clears the results
    arm_start(rows[0], 16'd0);
    u_uut.clocks(2, 16'hA5C3);
    wr_reg(SGS_REG_CMD, 32'h2);
    rd_reg(SGS_REG_STATUS, v);
    chk("forced", {31'h0, v[2]}, 32'h1);
    expect_row('{16'h40E0, 1'b1, 2, 16'hA5C3}, 1'b0, es, ee);
    rd_reg(SGS_REG_SIG, v);
    chk("forced sig", v, {16'h0, es});
    wr_reg(SGS_REG_CMD, 32'h3);
    results(SGS_SIG_RESET, 0, 2'h1);
    $display("forced read test done");
    summarize();
  end
endmodule
